// File: rtl/cmo_params.svh
// Purpose: constants for the cache maintenance unit
// Assumes: included by rtl/cmo_unit.sv
// Notes: offsets are byte addresses on the register port
`ifndef CMO_PARAMS_SVH
`define CMO_PARAMS_SVH
// ==========================================
// register offsets
`define CMO_OFS_TAG_LO 5'h00
`define CMO_OFS_TAG_HI 5'h04
`define CMO_OFS_DAT_LO 5'h08
`define CMO_OFS_DAT_HI 5'h0c
`define CMO_OFS_STATUS 5'h10
// ==========================================
// tag low fields and attributes
`define CMO_TL_VALID 0
`define CMO_TL_DIRTY 1
`define CMO_TL_LOCK 2
`define CMO_TL_TAG 3
`define CMO_LINE_OFS 3
`define CMO_CCA_COH_A 3'h4
`define CMO_CCA_COH_B 3'h5
`define CMO_RST_WORD 32'h0000_0000
`endif

// File: rtl/cmo_pkg.sv
// Purpose: types for the cache maintenance unit
// Assumes: nothing
// Notes: codes follow instruction bits 20:16
package cmo_pkg;
    typedef enum logic [1:0] {
        CMO_C_INS = 2'h0, CMO_C_DAT = 2'h1, CMO_C_TER = 2'h2, CMO_C_SEC = 2'h3
    } cmo_cache_e;
    typedef enum logic [2:0] {
        CMO_IDX_INV = 3'h0, CMO_LD_TAG = 3'h1, CMO_ST_TAG = 3'h2, CMO_IMPL = 3'h3,
        CMO_HIT_INV = 3'h4, CMO_HIT_WBI = 3'h5, CMO_HIT_WB = 3'h6, CMO_LOCK = 3'h7
    } cmo_op_e;
    typedef enum logic [3:0] {
        CMO_IDLE = 4'h1, CMO_LOOK = 4'h2, CMO_WB = 4'h4, CMO_FILL = 4'h8
    } cmo_state_e;
    typedef struct packed {
        cmo_op_e op;
        cmo_cache_e cache;
        logic [31:0] base;
        logic [15:0] offset;
        logic [2:0] coherency_attribute;
    } cmo_req_s;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [63:0] wdata;
    } cmo_mem_s;
endpackage

// File: rtl/cmo_unit.sv
// Purpose: executes cache maintenance operations on four small caches
// Assumes: issuer keeps req_i steady while req_valid_i is high and ready
// Notes: direct-mapped caches, one 64-bit word per line
`timescale 1ns/1ns
`include "cmo_params.svh"
module cmo_unit #(
    parameter int IDX_W = 4,
    parameter bit INCLUSIVE = 1'b1,
    parameter bit HAS_DATA_REGS = 1'b1
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire cmo_pkg::cmo_req_s req_i,
    input wire logic cp0_usable_i,
    input wire logic [3:0] wt_mode_i,
    output logic ready_o,
    output logic done_o,
    output logic unusable_o,
    output logic cache_err_o,
    output logic bcast_o,
    output logic [31:0] bcast_addr_o,
    output cmo_pkg::cmo_mem_s mem_o,
    input wire logic mem_ack_i,
    input wire logic mem_err_i,
    input wire logic [63:0] mem_rdata_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o
);
    import cmo_pkg::*;

    localparam int LINES = 1 << IDX_W;
    localparam int TAG_W = 32 - IDX_W - `CMO_LINE_OFS;

    // ==========================================
    // storage
    logic [TAG_W-1:0] tag_ff [4][LINES];
    logic [63:0] data_ff [4][LINES];
    logic val_ff [4][LINES];
    logic dirty_ff [4][LINES];
    logic lock_ff [4][LINES];
    logic [31:0] tag_low_reg_ff, tag_high_reg_ff, line_data_low_reg_ff, line_data_high_reg_ff;

    cmo_state_e st_ff;
    cmo_op_e op_ff;
    cmo_cache_e cur_ff, tgt_ff;
    logic pend_ff, coh_ff, done_ff, unus_ff, cerr_ff, bcast_ff;
    logic [31:0] ea_ff, rdata_ff;
    cmo_mem_s mem_ff;

    // ==========================================
    // helpers
    function automatic logic is_hit_op(input cmo_op_e op, input cmo_cache_e c);
        is_hit_op = (op == CMO_HIT_INV) || (op == CMO_HIT_WB) ||
            (op == CMO_HIT_WBI && c != CMO_C_INS);
    endfunction

    function automatic logic [31:0] line_addr(input logic [TAG_W-1:0] t,
                                              input logic [IDX_W-1:0] i);
        line_addr = {t, i, 3'h0};
    endfunction

    logic accept, lv, ld, hit, wback, lvl_end, hit_kind;
    logic do_inv, do_lock, do_stag, do_ldt, go_wb, go_fill;
    logic [31:0] ea;
    logic [IDX_W-1:0] idx;
    logic [TAG_W-1:0] atag;

    assign accept = st_ff == CMO_IDLE && req_valid_i && ce_i;
    assign ea = req_i.base + {{16{req_i.offset[15]}}, req_i.offset};
    assign idx = ea_ff[`CMO_LINE_OFS +: IDX_W];
    assign atag = ea_ff[31 -: TAG_W];
    assign lv = val_ff[cur_ff][idx];
    assign ld = lv && dirty_ff[cur_ff][idx];
    assign hit = lv && tag_ff[cur_ff][idx] == atag;
    // write-through caches and the instruction cache never write back
    assign wback = !wt_mode_i[cur_ff] && cur_ff != CMO_C_INS;

    // ==========================================
    // operation decode in the lookup cycle
    always_comb
    begin
        do_inv = 1'b0;
        do_lock = 1'b0;
        do_stag = 1'b0;
        do_ldt = 1'b0;
        go_wb = 1'b0;
        go_fill = 1'b0;
        if (st_ff == CMO_LOOK)
        begin
            unique case (op_ff)
                CMO_IDX_INV:
                begin
                    go_wb = wback && ld;
                    do_inv = !(wback && ld);
                end
                CMO_LD_TAG: do_ldt = 1'b1;
                CMO_ST_TAG: do_stag = 1'b1;
                CMO_IMPL: ;
                CMO_HIT_INV: do_inv = hit;
                CMO_HIT_WBI:
                begin
                    go_fill = cur_ff == CMO_C_INS;
                    go_wb = cur_ff != CMO_C_INS && hit && wback && ld;
                    do_inv = cur_ff != CMO_C_INS && hit && !(wback && ld);
                end
                CMO_HIT_WB: go_wb = hit && wback && ld;
                CMO_LOCK:
                begin
                    do_lock = hit;
                    go_wb = !hit && wback && ld;
                    go_fill = !hit && !(wback && ld);
                end
            endcase
        end
    end

    assign lvl_end = (st_ff == CMO_LOOK && !go_wb && !go_fill) ||
        (st_ff == CMO_WB && mem_ack_i && op_ff != CMO_LOCK) ||
        (st_ff == CMO_FILL && mem_ack_i);
    assign hit_kind = is_hit_op(op_ff, tgt_ff);

    // ==========================================
    // sequencing
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= CMO_IDLE;
            op_ff <= CMO_IDX_INV;
            cur_ff <= CMO_C_INS;
            tgt_ff <= CMO_C_INS;
            pend_ff <= 1'b0;
            coh_ff <= 1'b0;
            ea_ff <= `CMO_RST_WORD;
        end
        else if (ce_i)
        begin
            unique case (st_ff)
                CMO_IDLE:
                    if (accept && cp0_usable_i)
                    begin
                        st_ff <= CMO_LOOK;
                        op_ff <= req_i.op;
                        tgt_ff <= req_i.cache;
                        ea_ff <= ea;
                        // one decision for every level touched
                        coh_ff <= req_i.coherency_attribute == `CMO_CCA_COH_A ||
                            req_i.coherency_attribute == `CMO_CCA_COH_B;
                        // inner data cache is handled before the outer one
                        if (INCLUSIVE && req_i.cache[1] &&
                            (req_i.op == CMO_IDX_INV || req_i.op[2] && req_i.op != CMO_LOCK))
                        begin
                            cur_ff <= CMO_C_DAT;
                            pend_ff <= 1'b1;
                        end
                        else
                        begin
                            cur_ff <= req_i.cache;
                            pend_ff <= 1'b0;
                        end
                    end
                CMO_LOOK:
                    if (go_wb)
                        st_ff <= CMO_WB;
                    else if (go_fill)
                        st_ff <= CMO_FILL;
                CMO_WB:
                    if (mem_ack_i && op_ff == CMO_LOCK)
                        st_ff <= CMO_FILL;
                CMO_FILL: ;
                default: st_ff <= CMO_IDLE;
            endcase
            if (lvl_end)
            begin
                pend_ff <= 1'b0;
                cur_ff <= tgt_ff;
                st_ff <= pend_ff ? CMO_LOOK : CMO_IDLE;
            end
        end
    end

    // ==========================================
    // line state updates
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            for (int c = 0; c < 4; c++)
            begin
                for (int i = 0; i < LINES; i++)
                begin
                    val_ff[c][i] <= 1'b0;
                    dirty_ff[c][i] <= 1'b0;
                    lock_ff[c][i] <= 1'b0;
                end
            end
        end
        else if (ce_i)
        begin
            if (do_inv)
            begin
                val_ff[cur_ff][idx] <= 1'b0;
                dirty_ff[cur_ff][idx] <= 1'b0;
                lock_ff[cur_ff][idx] <= 1'b0;
            end
            if (do_lock)
                lock_ff[cur_ff][idx] <= 1'b1;
            if (do_stag)
            begin
                tag_ff[cur_ff][idx] <= tag_low_reg_ff[`CMO_TL_TAG +: TAG_W];
                val_ff[cur_ff][idx] <= tag_low_reg_ff[`CMO_TL_VALID];
                dirty_ff[cur_ff][idx] <= tag_low_reg_ff[`CMO_TL_DIRTY];
                lock_ff[cur_ff][idx] <= tag_low_reg_ff[`CMO_TL_LOCK];
            end
            if (st_ff == CMO_WB && mem_ack_i)
            begin
                dirty_ff[cur_ff][idx] <= 1'b0;
                if (op_ff != CMO_HIT_WB)
                begin
                    val_ff[cur_ff][idx] <= 1'b0;
                    lock_ff[cur_ff][idx] <= 1'b0;
                end
            end
            // only the addressed line is fetched, and it is locked only by a fetch-and-lock
            if (st_ff == CMO_FILL && mem_ack_i)
            begin
                tag_ff[cur_ff][idx] <= atag;
                data_ff[cur_ff][idx] <= mem_rdata_i;
                val_ff[cur_ff][idx] <= 1'b1;
                dirty_ff[cur_ff][idx] <= 1'b0;
                lock_ff[cur_ff][idx] <= op_ff == CMO_LOCK;
            end
        end
    end

    // ==========================================
    // next memory level port
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            mem_ff <= '0;
            cerr_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            // only writebacks and fills can fault, so tag ops never do
            cerr_ff <= (st_ff == CMO_WB || st_ff == CMO_FILL) && mem_ack_i && mem_err_i;
            if (go_wb)
            begin
                mem_ff.req <= 1'b1;
                mem_ff.we <= 1'b1;
                mem_ff.addr <= line_addr(tag_ff[cur_ff][idx], idx);
                mem_ff.wdata <= data_ff[cur_ff][idx];
            end
            else if (go_fill || (st_ff == CMO_WB && mem_ack_i && op_ff == CMO_LOCK))
            begin
                mem_ff.req <= 1'b1;
                mem_ff.we <= 1'b0;
                mem_ff.addr <= line_addr(atag, idx);
            end
            else if (mem_ack_i)
                mem_ff.req <= 1'b0;
        end
    end

    // ==========================================
    // completion and exception pulses
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            done_ff <= 1'b0;
            unus_ff <= 1'b0;
            bcast_ff <= 1'b0;
            bcast_addr_o <= `CMO_RST_WORD;
        end
        else if (ce_i)
        begin
            done_ff <= lvl_end && !pend_ff;
            unus_ff <= accept && !cp0_usable_i;
            bcast_ff <= lvl_end && !pend_ff && coh_ff && is_hit_op(op_ff, tgt_ff);
            if (lvl_end && !pend_ff)
                bcast_addr_o <= ea_ff;
        end
    end

    // ==========================================
    // register port; a load tag in the same cycle wins over software
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            tag_low_reg_ff <= `CMO_RST_WORD;
            tag_high_reg_ff <= `CMO_RST_WORD;
            line_data_low_reg_ff <= `CMO_RST_WORD;
            line_data_high_reg_ff <= `CMO_RST_WORD;
        end
        else if (ce_i)
        begin
            if (reg_wr_i)
            begin
                unique case (reg_addr_i)
                    `CMO_OFS_TAG_LO: tag_low_reg_ff <= reg_wdata_i;
                    `CMO_OFS_TAG_HI: tag_high_reg_ff <= reg_wdata_i;
                    `CMO_OFS_DAT_LO: line_data_low_reg_ff <= reg_wdata_i;
                    `CMO_OFS_DAT_HI: line_data_high_reg_ff <= reg_wdata_i;
                    default: ;
                endcase
            end
            if (do_ldt)
            begin
                tag_low_reg_ff <= 32'({tag_ff[cur_ff][idx], lock_ff[cur_ff][idx],
                    dirty_ff[cur_ff][idx], lv});
                tag_high_reg_ff <= line_addr(tag_ff[cur_ff][idx], idx);
                if (HAS_DATA_REGS)
                begin
                    line_data_low_reg_ff <= data_ff[cur_ff][idx][31:0];
                    line_data_high_reg_ff <= data_ff[cur_ff][idx][63:32];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            rdata_ff <= `CMO_RST_WORD;
        else if (ce_i)
        begin
            rdata_ff <= `CMO_RST_WORD;
            if (reg_rd_i)
            begin
                unique case (reg_addr_i)
                    `CMO_OFS_TAG_LO: rdata_ff <= tag_low_reg_ff;
                    `CMO_OFS_TAG_HI: rdata_ff <= tag_high_reg_ff;
                    `CMO_OFS_DAT_LO: rdata_ff <= line_data_low_reg_ff;
                    `CMO_OFS_DAT_HI: rdata_ff <= line_data_high_reg_ff;
                    `CMO_OFS_STATUS: rdata_ff <= {28'h0, st_ff};
                    default: ;
                endcase
            end
        end
    end

    assign ready_o = st_ff[0]; // idle is bit 0 of the one-hot state flop
    assign done_o = done_ff;
    assign unusable_o = unus_ff;
    assign cache_err_o = cerr_ff;
    assign bcast_o = bcast_ff;
    assign mem_o = mem_ff;
    assign reg_rdata_o = rdata_ff;

    // ==========================================
    // checks
    sequence s_wb_ack;
        st_ff == CMO_WB && mem_ack_i && ce_i;
    endsequence
    a_refuse_no_cp0: assert property (@(posedge core_clk_i) disable iff (rst_i)
        accept && !cp0_usable_i |=> unusable_o && st_ff == CMO_IDLE)
        else $error("refused op did not raise unusable");
    a_tag_op_err: assert property (@(posedge core_clk_i) disable iff (rst_i)
        cache_err_o |-> $past(op_ff) != CMO_LD_TAG && $past(op_ff) != CMO_ST_TAG)
        else $error("cache error from a tag operation");
    a_wt_no_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        st_ff == CMO_WB |-> !wt_mode_i[cur_ff] && mem_o.we && mem_o.req)
        else $error("writeback on a write-through cache");
    a_bcast_coh: assert property (@(posedge core_clk_i) disable iff (rst_i)
        bcast_o |-> $past(coh_ff) && $past(hit_kind))
        else $error("broadcast of a non-coherent operation");
    a_wbinv_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_wb_ack ##0 (op_ff == CMO_IDX_INV || op_ff == CMO_HIT_WBI) |=> !val_ff[$past(cur_ff)][idx])
        else $error("line still valid after writeback-invalidate");
    a_hitwb_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_wb_ack ##0 op_ff == CMO_HIT_WB |=> val_ff[$past(cur_ff)][idx] &&
            !dirty_ff[$past(cur_ff)][idx])
        else $error("hit writeback did not keep line valid and clean");
    a_lock_fill: assert property (@(posedge core_clk_i) disable iff (rst_i)
        st_ff == CMO_FILL && mem_ack_i && ce_i && op_ff == CMO_LOCK |=>
            lock_ff[$past(cur_ff)][idx] && val_ff[$past(cur_ff)][idx])
        else $error("fetch-and-lock left line unlocked");
    a_ldtag_copy: assert property (@(posedge core_clk_i) disable iff (rst_i)
        do_ldt && ce_i |=> tag_low_reg_ff[`CMO_TL_VALID] == $past(lv))
        else $error("load tag did not copy valid bit");
    a_inner_first: assert property (@(posedge core_clk_i) disable iff (rst_i)
        st_ff == CMO_LOOK && pend_ff |-> cur_ff == CMO_C_DAT)
        else $error("outer cache handled before inner");
endmodule

// File: bench/cmo_mem_model.sv
// Purpose: next memory level seen by the maintenance unit
// Assumes: requests held on mem_i until acknowledged
// Notes: slow_i stretches every answer and flags it with an error
`timescale 1ns/1ns
module cmo_mem_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire cmo_pkg::cmo_mem_s mem_i,
    output logic ack_o,
    output logic err_o,
    output logic [63:0] rdata_o,
    output logic [15:0] n_wr_o,
    output logic [15:0] n_rd_o,
    output logic [31:0] wr_addr_o
);
    import cmo_pkg::*;
    logic [2:0] wait_ff;
    logic [63:0] data_ff;
    // =====
    // answer
    // released data shows the inverse, so a late sample never matches
    assign rdata_o = ack_o ? data_ff : ~data_ff;
    // slow answers carry an error so that tag operations are seen to ignore it
    assign err_o = ack_o && slow_i;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            wait_ff <= 3'h0;
            n_wr_o <= 16'h0;
            n_rd_o <= 16'h0;
            wr_addr_o <= 32'h0;
            data_ff <= 64'h0;
        end
        else
        begin
            ack_o <= 1'b0;
            if (mem_i.req && !ack_o && wait_ff >= (slow_i ? 3'h4 : 3'h0))
            begin
                ack_o <= 1'b1;
                wait_ff <= 3'h0;
                data_ff <= {mem_i.addr, ~mem_i.addr};
                if (mem_i.we)
                begin
                    n_wr_o <= n_wr_o + 16'h1;
                    wr_addr_o <= mem_i.addr;
                end
                else
                begin
                    n_rd_o <= n_rd_o + 16'h1;
                end
            end
            else if (mem_i.req && !ack_o)
            begin
                wait_ff <= wait_ff + 3'h1;
            end
        end
    end
endmodule

// File: bench/cmo_unit_tb.sv
// Purpose: self-checking bench for the cache maintenance unit
// Assumes: tag field sits at bit 3 of tag low and holds address bits 31:7
// Notes: every request uses a random offset, base is adjusted to match
`timescale 1ns/1ns
module cmo_unit_tb;
    import cmo_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic cp0_usable_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic slow = 1'b0;
    cmo_req_s req_i = '0;
    logic [3:0] wt_mode_i = 4'h1;
    logic [4:0] reg_addr_i = 5'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [31:0] reg_rdata_o, bcast_addr_o, wr_addr, rd, ba, seed_v;
    logic ready_o, done_o, unusable_o, cache_err_o, bcast_o, mem_ack_i, mem_err_i;
    logic g_done, g_unu, g_err, g_bc;
    cmo_mem_s mem_o;
    logic [63:0] mem_rdata_i;
    logic [15:0] n_wr, n_rd, dw, dr;
    logic [2:0] ro;
    int n_errors = 0;
    int checked = 0;
    localparam logic [31:0] A = 32'h1234_5678;
    localparam logic [31:0] B = 32'h1334_5678;
    localparam logic [31:0] N = 32'h1234_5680;
    initial forever #10 core_clk_i = ~core_clk_i;
    cmo_unit i_cmo_unit (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .cp0_usable_i(cp0_usable_i),
        .wt_mode_i(wt_mode_i), .ready_o(ready_o), .done_o(done_o), .unusable_o(unusable_o),
        .cache_err_o(cache_err_o), .bcast_o(bcast_o), .bcast_addr_o(bcast_addr_o),
        .mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_err_i(mem_err_i),
        .mem_rdata_i(mem_rdata_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    cmo_mem_model i_cmo_mem_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
        .mem_i(mem_o), .ack_o(mem_ack_i), .err_o(mem_err_i), .rdata_o(mem_rdata_i),
        .n_wr_o(n_wr), .n_rd_o(n_rd), .wr_addr_o(wr_addr));
    // =====
    // tasks
    task finish_test;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    function automatic logic [31:0] tl(input logic [31:0] ea, input logic [2:0] b);
        return {4'h0, ea[31:7], b};
    endfunction
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rdr(input logic [4:0] a);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        rd = reg_rdata_o;
    endtask
    task op(input logic [2:0] o, input logic [1:0] c, input logic [31:0] ea,
            input logic [2:0] at);
        logic [15:0] off, w0, r0;
        int i;
        off = 16'($urandom);
        w0 = n_wr;
        r0 = n_rd;
        @(posedge core_clk_i);
        req_valid_i <= 1'b1;
        req_i <= '{op: cmo_op_e'(o), cache: cmo_cache_e'(c),
            base: ea - {{16{off[15]}}, off}, offset: off, coherency_attribute: at};
        @(posedge core_clk_i);
        req_valid_i <= 1'b0;
        {g_done, g_unu, g_err, g_bc} = 4'h0;
        for (i = 0; i < 300 && !(g_done || g_unu); i++)
        begin
            @(negedge core_clk_i);
            g_done = done_o;
            g_unu = unusable_o;
            g_bc = bcast_o;
            g_err = g_err | cache_err_o;
            ba = bcast_addr_o;
        end
        if (!(g_done || g_unu))
        begin
            $display("Error op answer expected 1 seen 0");
            n_errors++;
            finish_test;
        end
        dw = n_wr - w0; // writes are counted once done or unusable is seen
        dr = n_rd - r0;
    endtask
    task st(input logic [1:0] c, input logic [31:0] ea, input logic [2:0] b);
        wr(5'h00, tl(ea, b));
        op(3'h2, c, ea, 3'h0);
        chk("store err", 0, 32'(g_err));
    endtask
    task lt(input string nm, input logic [1:0] c, input logic [31:0] ea, input logic [2:0] b);
        op(3'h1, c, ea, 3'h0);
        chk("load err", 0, 32'(g_err));
        rdr(5'h00);
        chk(nm, tl(ea, b), rd);
    endtask
    // =====
    // sequence
    initial
    begin
        seed_v = $urandom(50);
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rdr(5'h10);
        chk("status", 1, rd);
        rdr(5'h14);
        chk("unmapped", 0, rd);
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        rdr(5'h10);
        chk("frozen read", 0, rd);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        $display("test reset done");
        @(posedge core_clk_i);
        cp0_usable_i <= 1'b0;
        op(3'h4, 2'h1, A, 3'h4);
        chk("unusable", 1, 32'(g_unu));
        chk("no done", 0, 32'(g_done));
        @(posedge core_clk_i);
        cp0_usable_i <= 1'b1;
        st(2'h1, A, 3'h3);
        lt("tag dirty", 2'h1, A, 3'h3);
        op(3'h6, 2'h1, A, 3'h0);
        chk("hwb writes", 1, 32'(dw));
        chk("hwb addr", {A[31:3], 3'h0}, wr_addr);
        lt("hwb state", 2'h1, A, 3'h1);
        st(2'h1, A, 3'h3);
        op(3'h5, 2'h1, A, 3'h0);
        chk("hwbi writes", 1, 32'(dw));
        lt("hwbi state", 2'h1, A, 3'h0);
        st(2'h1, A, 3'h3);
        op(3'h0, 2'h1, A, 3'h0);
        chk("iwbi addr", {A[31:3], 3'h0}, wr_addr);
        lt("iwbi state", 2'h1, A, 3'h0);
        $display("test writeback done");
        @(posedge core_clk_i);
        wt_mode_i <= 4'h3;
        st(2'h1, A, 3'h3);
        op(3'h6, 2'h1, A, 3'h0);
        chk("wt hwb", 0, 32'(dw));
        op(3'h5, 2'h1, A, 3'h0);
        chk("wt hwbi", 0, 32'(dw));
        lt("wt hwbi state", 2'h1, A, 3'h0);
        st(2'h1, A, 3'h3);
        op(3'h0, 2'h1, A, 3'h0);
        chk("wt iwbi", 0, 32'(dw));
        lt("wt iwbi state", 2'h1, A, 3'h0);
        @(posedge core_clk_i);
        wt_mode_i <= 4'h1;
        $display("test write-through done");
        slow <= 1'b1;
        st(2'h1, B, 3'h3);
        op(3'h7, 2'h1, A, 3'h0);
        chk("lock victim", 1, 32'(dw));
        chk("lock fill", 1, 32'(dr));
        chk("lock err", 1, 32'(g_err));
        lt("locked", 2'h1, A, 3'h5);
        op(3'h1, 2'h1, N, 3'h0);
        rdr(5'h00);
        chk("neighbour", 0, {29'h0, rd[2:0]});
        op(3'h7, 2'h1, A, 3'h0);
        chk("lock hit", 0, 32'(dw + dr));
        op(3'h4, 2'h1, A, 3'h4);
        chk("bcast", 1, 32'(g_bc));
        chk("bcast addr", A, ba);
        lt("unlocked", 2'h1, A, 3'h0);
        slow <= 1'b0;
        st(2'h1, A, 3'h1);
        op(3'h4, 2'h1, A, 3'h2);
        chk("no bcast", 0, 32'(g_bc));
        $display("test lock done");
        st(2'h0, A, 3'h1);
        op(3'h0, 2'h0, A, 3'h0);
        lt("icache inv", 2'h0, A, 3'h0);
        op(3'h5, 2'h0, A, 3'h0);
        chk("icache fill", 1, 32'(dr));
        lt("icache filled", 2'h0, A, 3'h1);
        st(2'h1, A, 3'h3);
        st(2'h3, A, 3'h3);
        op(3'h5, 2'h3, A, 3'h5);
        chk("two levels", 2, 32'(dw));
        chk("one bcast", 1, 32'(g_bc));
        lt("inner first", 2'h1, A, 3'h0);
        $display("test levels done");
        // only the data cache is exercised at random, with 40 random op and attribute picks
        repeat (40)
        begin
            ro = 3'($urandom_range(7, 0));
            wr(5'h00, $urandom);
            op(ro, 2'h1, $urandom, 3'($urandom_range(7, 0)));
            chk("random done", 1, 32'(g_done));
            if (ro == 3'h1 || ro == 3'h2)
                chk("random err", 0, 32'(g_err));
        end
        $display("test random done");
        finish_test;
    end
endmodule
